// [verilog/pdw_defs.svh]
`ifndef PDW_DEFS_SVH
`define PDW_DEFS_SVH
// Functional notes
// - wait select codes give 8192,16384,1024,2048,4096,2,8,16 states
// - control two bits 7 to 5 read as one and ignore writes
// - noise select bit: zero samples watch clock at osc/16, one at osc/4
// - direct transfer flag joins the other flags in picking sleep target
// - medium flag picks high or medium active mode on resume
// - subactive clock select sets subclock rate; kept in subactive
// - wait count applies on interrupt wake to active from standby, watch or subsleep, not from sleep; cpu held until done

// register map, 8-bit data
`define PDW_AW          4
`define PDW_ADDR_CTRL2  4'h0
`define PDW_ADDR_WSEL   4'h1
`define PDW_ADDR_STAT   4'h2
`define PDW_CTRL2_RST   8'hf0
`define PDW_RSVD_ONES   3'h7
`define PDW_WSEL_RST    3'h0
`define PDW_RD_NONE     8'h00
`define PDW_B_NOISE_FILTER_RATE_SEL     4
`define PDW_B_DIRECT_TRANSFER_FLAG      3
`define PDW_B_MEDIUM_SPEED_RESUME_FLAG      2
`define PDW_SA_HI       1
`define PDW_SA_LO       0
`define PDW_WSEL_HI     2
`define PDW_WSEL_PAD    5'h00
`define PDW_STAT_PAD    4'h0

// wait select codes
`define PDW_WS_8K       3'h0
`define PDW_WS_16K      3'h1
`define PDW_WS_1K       3'h2
`define PDW_WS_2K       3'h3
`define PDW_WS_4K       3'h4
`define PDW_WS_EXT      3'h5
`define PDW_WS_8        3'h6
`define PDW_WS_16       3'h7

// wait lengths in states
`define PDW_CW          15
`define PDW_WAIT_1K     15'h0400
`define PDW_WAIT_2K     15'h0800
`define PDW_WAIT_4K     15'h1000
`define PDW_WAIT_EXT    15'h0002
`define PDW_WAIT_8      15'h0008
`define PDW_WAIT_16     15'h0010
`define PDW_CNT_ZERO    15'h0000
`define PDW_CNT_ONE     15'h0001

// noise sampler prescaler
`define PDW_PRE_ZERO    4'h0
`define PDW_PRE_ONE     4'h1
`define PDW_DIV16_LAST  4'hf
`define PDW_DIV4_LAST   2'h3
`endif

// [verilog/pdw_pkg.sv]
package pdw_pkg;

   typedef enum logic [2:0] {
      M_HIGH, M_MED, M_SLEEP, M_STBY, M_WATCH, M_SUBACT, M_SUBSLP, M_WAIT
   } pdw_mode_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       noise_filter_rate_sel;
      logic       direct_transfer_flag;
      logic       medium_speed_resume_flag;
      logic [1:0] sa;
   } pdw_ctl2_t;

   typedef struct packed {
      logic deep_standby_select;
      logic timer_mode_select;
      logic low_speed_resume_flag;
   } pdw_cfg1_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pdw_bus_t;

endpackage

// [verilog/pdw_top.sv]
`include "pdw_defs.svh"

module pdw_top #(
   parameter int WAIT_8K  = 8192,
   parameter int WAIT_16K = 16384
) (
   input  wire logic               MCLK_I,
   input  wire logic               NRST_I,
   input  wire pdw_pkg::pdw_bus_t  BUS_I,
   output logic [7:0]              RDATA_O,
   input  wire pdw_pkg::pdw_cfg1_t CTRL_ONE_I,
   input  wire logic               SLEEP_EXEC_I,
   input  wire logic               WAKE_I,
   input  wire logic               WATCH_CLK_I,
   output logic                    CPU_HOLD_O,
   output pdw_pkg::pdw_mode_t      MODE_O,
   output logic [1:0]              SUB_CLK_SEL_O,
   output logic                    WATCH_CLK_O
);
   import pdw_pkg::*;

   localparam int CW = `PDW_CW;

   ////////////////////////////////////////////////////////////////////////
   // wait length decode

   function automatic logic [CW-1:0] wait_len(input logic [2:0] sel);
      logic [CW-1:0] len;
      len = `PDW_WAIT_16;
      unique case (sel)
         `PDW_WS_8K:  len = CW'(WAIT_8K);
         `PDW_WS_16K: len = CW'(WAIT_16K);
         `PDW_WS_1K:  len = `PDW_WAIT_1K;
         `PDW_WS_2K:  len = `PDW_WAIT_2K;
         `PDW_WS_4K:  len = `PDW_WAIT_4K;
         `PDW_WS_EXT: len = `PDW_WAIT_EXT;
         `PDW_WS_8:   len = `PDW_WAIT_8;
         `PDW_WS_16:  len = `PDW_WAIT_16;
      endcase
      return len;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   pdw_ctl2_t       ctl2;
   pdw_ctl2_t       next_ctl2;
   logic [2:0]      wsel;
   logic [2:0]      next_wsel;
   logic [7:0]      rdata;
   logic [7:0]      next_rdata;
   pdw_mode_t       mode;
   pdw_mode_t       next_mode;
   logic [CW-1:0]   cnt;
   logic [CW-1:0]   next_cnt;
   logic [CW-1:0]   wait_last;
   logic [3:0]      pre;
   logic [3:0]      next_pre;
   logic            w_s1;
   logic            w_s2;
   logic            w_last;
   logic            next_w_last;
   logic            w_filt;
   logic            next_w_filt;
   logic            tick;
   logic            wr_ctl2;

   assign wait_last = wait_len(wsel) - `PDW_CNT_ONE;
   assign wr_ctl2   = BUS_I.wr && (BUS_I.addr == `PDW_ADDR_CTRL2);

   ////////////////////////////////////////////////////////////////////////
   // register file

   always_comb begin
      next_ctl2  = ctl2;
      next_wsel  = wsel;
      next_rdata = rdata;
      if (wr_ctl2) begin
         next_ctl2.noise_filter_rate_sel = BUS_I.wdata[`PDW_B_NOISE_FILTER_RATE_SEL];
         next_ctl2.direct_transfer_flag  = BUS_I.wdata[`PDW_B_DIRECT_TRANSFER_FLAG];
         next_ctl2.medium_speed_resume_flag  = BUS_I.wdata[`PDW_B_MEDIUM_SPEED_RESUME_FLAG];
         if (mode != M_SUBACT) begin
            next_ctl2.sa = BUS_I.wdata[`PDW_SA_HI:`PDW_SA_LO];
         end
      end
      next_ctl2.rsvd = `PDW_RSVD_ONES;
      if (BUS_I.wr && (BUS_I.addr == `PDW_ADDR_WSEL)) begin
         next_wsel = BUS_I.wdata[`PDW_WSEL_HI:0];
      end
      if (BUS_I.rd) begin
         unique case (BUS_I.addr)
            `PDW_ADDR_CTRL2: next_rdata = ctl2;
            `PDW_ADDR_WSEL:  next_rdata = {`PDW_WSEL_PAD, wsel};
            `PDW_ADDR_STAT:  next_rdata = {`PDW_STAT_PAD, CPU_HOLD_O, mode};
            default:         next_rdata = `PDW_RD_NONE;
         endcase
      end else begin
         next_rdata = `PDW_RD_NONE;
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctl2  <= `PDW_CTRL2_RST;
         wsel  <= `PDW_WSEL_RST;
         rdata <= `PDW_RD_NONE;
      end else begin
         ctl2  <= next_ctl2;
         wsel  <= next_wsel;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode sequencer and stabilisation wait

   always_comb begin
      next_mode = mode;
      next_cnt  = cnt;
      unique case (mode)
         M_HIGH, M_MED: begin
            if (SLEEP_EXEC_I) begin
               if (ctl2.direct_transfer_flag) begin
                  if (CTRL_ONE_I.low_speed_resume_flag) begin
                     next_mode = M_SUBACT;
                  end else begin
                     next_mode = ctl2.medium_speed_resume_flag ? M_MED : M_HIGH;
                  end
               end else if (CTRL_ONE_I.deep_standby_select) begin
                  next_mode = CTRL_ONE_I.timer_mode_select ? M_WATCH
                                                           : M_STBY;
               end else begin
                  next_mode = CTRL_ONE_I.low_speed_resume_flag ? M_SUBSLP
                                                               : M_SLEEP;
               end
            end
         end
         M_SUBACT: begin
            if (SLEEP_EXEC_I) begin
               next_cnt = `PDW_CNT_ZERO;
               if (ctl2.direct_transfer_flag && !CTRL_ONE_I.low_speed_resume_flag) begin
                  next_mode = M_WAIT;
               end else if (CTRL_ONE_I.deep_standby_select) begin
                  next_mode = CTRL_ONE_I.timer_mode_select ? M_WATCH
                                                           : M_STBY;
               end else begin
                  next_mode = M_SUBSLP;
               end
            end
         end
         M_SLEEP: begin
            if (WAKE_I) begin
               next_mode = ctl2.medium_speed_resume_flag ? M_MED : M_HIGH;
            end
         end
         M_STBY: begin
            if (WAKE_I) begin
               next_mode = M_WAIT;
               next_cnt  = `PDW_CNT_ZERO;
            end
         end
         M_WATCH, M_SUBSLP: begin
            if (WAKE_I) begin
               next_cnt = `PDW_CNT_ZERO;
               next_mode = CTRL_ONE_I.low_speed_resume_flag ? M_SUBACT
                                                            : M_WAIT;
            end
         end
         M_WAIT: begin
            next_cnt = cnt + `PDW_CNT_ONE;
            if (cnt == wait_last) begin
               next_mode = ctl2.medium_speed_resume_flag ? M_MED : M_HIGH;
               next_cnt  = `PDW_CNT_ZERO;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mode <= M_HIGH;
         cnt  <= `PDW_CNT_ZERO;
      end else begin
         mode <= next_mode;
         cnt  <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watch clock noise sampler

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         w_s1 <= 1'b0;
         w_s2 <= 1'b0;
      end else begin
         w_s1 <= WATCH_CLK_I;
         w_s2 <= w_s1;
      end
   end

   assign tick = ctl2.noise_filter_rate_sel ? (pre[1:0] == `PDW_DIV4_LAST)
                            : (pre == `PDW_DIV16_LAST);

   always_comb begin
      next_pre    = pre + `PDW_PRE_ONE;
      next_w_last = w_last;
      next_w_filt = w_filt;
      if (tick) begin
         next_w_last = w_s2;
         if (w_s2 == w_last) begin
            next_w_filt = w_s2;
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pre    <= `PDW_PRE_ZERO;
         w_last <= 1'b0;
         w_filt <= 1'b0;
      end else begin
         pre    <= next_pre;
         w_last <= next_w_last;
         w_filt <= next_w_filt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign RDATA_O       = rdata;
   assign MODE_O        = mode;
   assign CPU_HOLD_O    = (mode == M_WAIT);
   assign SUB_CLK_SEL_O = ctl2.sa;
   assign WATCH_CLK_O   = w_filt;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!NRST_I);

   logic [15:0] a_cnt;
   logic [15:0] a_len;

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         a_cnt <= 16'h0000;
         a_len <= 16'h0000;
      end else if (mode != M_WAIT && next_mode == M_WAIT) begin
         a_cnt <= 16'h0000;
         a_len <= {1'b0, wait_len(wsel)};
      end else if (mode == M_WAIT) begin
         a_cnt <= a_cnt + 16'h0001;
      end
   end

   wait_length_a: assert property (
      (mode == M_WAIT && next_mode != M_WAIT
       && a_len == {1'b0, wait_len(wsel)})
      |=> (a_cnt == a_len))
      else $error("stabilisation wait length wrong");

   wait_release_a: assert property (
      (mode == M_WAIT && cnt == wait_last) |=> !CPU_HOLD_O)
      else $error("cpu not released after terminal count");

   rsvd_ones_a: assert property (
      (BUS_I.rd && BUS_I.addr == `PDW_ADDR_CTRL2)
      |=> (RDATA_O[7:5] == `PDW_RSVD_ONES))
      else $error("reserved bits not read as one");

   div4_tick_a: assert property (
      (tick && ctl2.noise_filter_rate_sel ##1 ctl2.noise_filter_rate_sel[*4]) |-> tick)
      else $error("divide by four sampling spacing wrong");

   div16_gap_a: assert property (
      (tick && !ctl2.noise_filter_rate_sel ##1 !ctl2.noise_filter_rate_sel[*8] ##1 !ctl2.noise_filter_rate_sel[*8])
      |-> tick)
      else $error("divide by sixteen sampling spacing wrong");

   direct_sub_a: assert property (
      (mode == M_HIGH && SLEEP_EXEC_I && ctl2.direct_transfer_flag
       && CTRL_ONE_I.low_speed_resume_flag) |=> (MODE_O == M_SUBACT))
      else $error("direct transfer did not reach subactive");

   resume_med_a: assert property (
      (mode == M_SLEEP && WAKE_I && ctl2.medium_speed_resume_flag) |=> (MODE_O == M_MED))
      else $error("medium speed resume not taken");

   sub_lock_a: assert property (
      (wr_ctl2 && mode == M_SUBACT) |=> $stable(SUB_CLK_SEL_O))
      else $error("subactive clock select changed in subactive");

   wake_hold_a: assert property (
      (mode == M_STBY && WAKE_I) |=> CPU_HOLD_O ##1 CPU_HOLD_O)
      else $error("cpu not held during stabilisation wait");

   direct_wait_a: assert property (
      (mode == M_SUBACT && SLEEP_EXEC_I && ctl2.direct_transfer_flag
       && !CTRL_ONE_I.low_speed_resume_flag) |=> CPU_HOLD_O)
      else $error("direct transfer from subactive skipped the wait");

   watch_entry_a: assert property (
      ((mode == M_HIGH || mode == M_MED) && SLEEP_EXEC_I && !ctl2.direct_transfer_flag
       && CTRL_ONE_I.deep_standby_select && CTRL_ONE_I.timer_mode_select)
      |=> (MODE_O == M_WATCH))
      else $error("sleep did not enter watch mode");

endmodule

// [tb/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pdw_pkg::*;

   localparam int W8K  = 32;
   localparam int W16K = 64;

   logic       mclk;
   logic       nrst;
   pdw_bus_t   bus;
   logic [7:0] rdata;
   pdw_cfg1_t  ctrl_one;
   logic       sleep_exec;
   logic       wake;
   logic       watch_in;
   logic       cpu_hold;
   pdw_mode_t  mode;
   logic [1:0] sub_clk_sel;
   logic       watch_out;
   int         failures;
   int         n_tests;

   pdw_top #(.WAIT_8K(W8K), .WAIT_16K(W16K)) pdw_top_i (
      .MCLK_I        (mclk),
      .NRST_I        (nrst),
      .BUS_I         (bus),
      .RDATA_O       (rdata),
      .CTRL_ONE_I    (ctrl_one),
      .SLEEP_EXEC_I  (sleep_exec),
      .WAKE_I        (wake),
      .WATCH_CLK_I   (watch_in),
      .CPU_HOLD_O    (cpu_hold),
      .MODE_O        (mode),
      .SUB_CLK_SEL_O (sub_clk_sel),
      .WATCH_CLK_O   (watch_out)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d failures=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      check({8'h00, rdata}, {8'h00, e});
   endtask

   task automatic set1(input logic [2:0] v);
      @(posedge mclk);
      ctrl_one <= v;
   endtask

   // pulse sleep (s=1) or wake (s=0) for one cycle, settle after taking edge
   task automatic ev(input logic s);
      @(posedge mclk);
      if (s)
         sleep_exec <= 1'b1;
      else
         wake <= 1'b1;
      @(posedge mclk);
      sleep_exec <= 1'b0;
      wake <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic reg_access;
      chk_rd(4'h0, 8'hf0);
      chk_rd(4'h1, 8'h00);
      wr(4'h0, 8'h00);
      chk_rd(4'h0, 8'he0);
      wr(4'h0, 8'h1f);
      chk_rd(4'h0, 8'hff);
      check({14'h0, sub_clk_sel}, 16'h3);
      wr(4'h5, 8'h00);
      chk_rd(4'h5, 8'h00);
      chk_rd(4'h0, 8'hff);
   endtask

   task automatic wait_codes;
      int exp_len[8];
      int n;
      exp_len = '{W8K, W16K, 1024, 2048, 4096, 2, 8, 16};
      set1(3'b100);
      for (int c = 0; c < 8; c++) begin
         wr(4'h1, 8'(c));
         wr(4'h0, {5'h02, c[0], 2'h0});
         ev(1'b1);
         check({13'h0, mode}, {13'h0, M_STBY});
         chk_rd(4'h2, 8'h03);
         ev(1'b0);
         check({13'h0, mode}, {13'h0, M_WAIT});
         n = 0;
         while (cpu_hold === 1'b1 && n < 20000) begin
            n++;
            @(posedge mclk);
            #1;
         end
         check(16'(n), 16'(exp_len[c]));
         check({13'h0, mode}, {13'h0, c[0] ? M_MED : M_HIGH});
      end
   endtask

   task automatic transfers;
      set1(3'b000);
      wr(4'h0, 8'h1c);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_MED});
      wr(4'h0, 8'h14);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_SLEEP});
      ev(1'b0);
      check({13'h0, mode}, {13'h0, M_MED});
      set1(3'b001);
      wr(4'h0, 8'h19);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_SUBACT});
      wr(4'h0, 8'h1a);
      chk_rd(4'h0, 8'hf9);
      check({14'h0, sub_clk_sel}, 16'h1);
      wr(4'h1, 8'h05);
      set1(3'b000);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_WAIT});
      @(posedge mclk);
      #1;
      check({15'h0, cpu_hold}, 16'h1);
      @(posedge mclk);
      #1;
      check({13'h0, mode}, {13'h0, M_HIGH});
      wr(4'h0, 8'h12);
      chk_rd(4'h0, 8'hf2);
      check({14'h0, sub_clk_sel}, 16'h2);
   endtask

   // wake into the stabilisation wait, expect mode m after len states
   task automatic resume(input int len, input pdw_mode_t m);
      ev(1'b0);
      check({13'h0, mode}, {13'h0, M_WAIT});
      repeat (len - 1) @(posedge mclk);
      #1;
      check({15'h0, cpu_hold}, 16'h1);
      @(posedge mclk);
      #1;
      check({13'h0, mode}, {13'h0, m});
   endtask

   task automatic low_power;
      wr(4'h1, 8'h06);
      set1(3'b110);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_WATCH});
      resume(8, M_HIGH);
      set1(3'b001);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_SUBSLP});
      ev(1'b0);
      check({13'h0, mode}, {13'h0, M_SUBACT});
      set1(3'b000);
      ev(1'b1);
      check({13'h0, mode}, {13'h0, M_SUBSLP});
      resume(8, M_HIGH);
   endtask

   // latency of the filtered watch clock after one input edge
   task automatic lat(input logic [7:0] c2, output int n);
      wr(4'h0, c2);
      repeat (40) @(posedge mclk);
      watch_in <= ~watch_in;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (watch_out !== watch_in && n < 80);
   endtask

   task automatic noise_rate;
      int n;
      lat(8'h10, n);
      check({15'h0, n <= 14}, 16'h1);
      lat(8'h00, n);
      check({15'h0, n > 15 && n <= 40}, 16'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      repeat (30000) @(posedge mclk);
      failures++;
      print_verdict;
   end

   initial begin
      failures = 0;
      n_tests = 0;
      nrst = 1'b0;
      bus = '0;
      ctrl_one = '0;
      sleep_exec = 1'b0;
      wake = 1'b0;
      watch_in = 1'b0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      reg_access;
      wait_codes;
      transfers;
      low_power;
      noise_rate;
      print_verdict;
   end
endmodule
